/* testbench/shp_host.sv */
`timescale 1ns/10ps
module shp_host (
	// clock
	input  wire logic core_clk,
	// spi pins
	output logic      sclk,
	output logic      ss_n,
	output logic      mosi,
	input  wire logic miso
);
	initial begin
		sclk = 1'b0;
		ss_n = 1'b1;
		mosi = 1'b0;
	end

	// 8 core cycles a bit: 5 MHz, well under the ceiling
	task automatic shift(input int n, input logic [7:0] b, output logic [7:0] r);
		r = 8'h00;
		for (int i = 0; i < n; i++) begin
			@(posedge core_clk);
			sclk <= 1'b0;
			mosi <= b[7-i];
			repeat (4) @(posedge core_clk);
			sclk <= 1'b1;
			r = {r[6:0], miso};
			repeat (3) @(posedge core_clk);
		end
	endtask : shift

	task automatic pins(input logic s, input logic c);
		@(posedge core_clk);
		ss_n <= s;
		sclk <= c;
		mosi <= ~mosi; // released line must not keep its level
		repeat (8) @(posedge core_clk);
	endtask : pins
endmodule : shp_host

/* testbench/testbench.sv */
`timescale 1ns/10ps
module testbench;
	logic       core_clk, rst, three_wire, svc_req;
	logic       miso_last  = 1'b0;
	logic       tx_restart = 1'b0;
	logic [2:0] strap      = 3'h1;
	logic       sclk, ss_n, mosi, miso_w, miso_o, miso_oe_n;
	logic       tx_taken, rx_valid, irq_n, spi_mode_sel;
	logic [7:0] rx_data;
	logic [7:0] tx_data    = 8'hA5;
	logic [7:0] tx_arr [2] = '{8'hA5, 8'h3C}; // 16'h3CA5, low byte first
	logic [7:0] rxq [$];
	int         tx_i = 0;
	int         errors, samples_checked;

	// no pull on the data-out wire: show a changed level when floating
	assign miso_w = miso_oe_n ? ~miso_last : miso_o;

	shp_port dut (
		.core_clk(core_clk), .rst(rst), .sclk(sclk), .ss_n(ss_n), .mosi(mosi),
		.miso_o(miso_o), .miso_oe_n(miso_oe_n), .mode_strap_bit0(strap[0]),
		.mode_strap_bit1(strap[1]), .mode_strap_bit2(strap[2]),
		.three_wire(three_wire), .spi_mode_sel(spi_mode_sel), .tx_data(tx_data),
		.tx_taken(tx_taken), .rx_data(rx_data), .rx_valid(rx_valid),
		.svc_req(svc_req), .irq_n(irq_n)
	);
	shp_host host (.core_clk(core_clk), .sclk(sclk), .ss_n(ss_n), .mosi(mosi), .miso(miso_w));

	initial begin
		core_clk = 1'b0;
		forever #12.5 core_clk = ~core_clk;
	end

	always @(posedge core_clk) begin
		if (!miso_oe_n) miso_last <= miso_o;
		if (rx_valid === 1'b1) rxq.push_back(rx_data);
		if (tx_restart) begin
			tx_i    <= 0;
			tx_data <= tx_arr[0];
		end else if (tx_taken === 1'b1) begin
			tx_i <= tx_i + 1;
			tx_data <= tx_arr[(tx_i + 1) % 2];
		end
	end

	task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
		samples_checked++;
		if (got !== exp) begin
			errors++;
			$display("BAD %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask : chk

	task automatic stop_test;
		if (errors == 0 && samples_checked > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask : stop_test

	task automatic t_reset;
		chk({7'h0, miso_oe_n}, 8'h01, "idle oe");
		chk({7'h0, irq_n}, 8'h01, "idle irq");
		chk({7'h0, spi_mode_sel}, 8'h01, "strap");
	endtask : t_reset

	task automatic t_four(input logic idle_hi);
		logic [7:0] r0, r1;
		host.pins(1'b1, idle_hi);
		@(posedge core_clk);
		tx_restart <= 1'b1;
		@(posedge core_clk);
		tx_restart <= 1'b0;
		rxq.delete();
		host.pins(1'b0, idle_hi);
		chk({7'h0, miso_oe_n}, 8'h00, "oe on select");
		host.shift(8, 8'h5A, r0);
		host.shift(8, 8'hC3, r1);
		host.pins(1'b0, idle_hi);
		host.pins(1'b1, idle_hi);
		chk({7'h0, miso_oe_n}, 8'h01, "oe off");
		chk(r0, 8'hA5, "miso byte0");
		chk(r1, 8'h3C, "miso byte1");
		chk(8'(rxq.size()), 8'h02, "rx count");
		chk(rxq[0], 8'h5A, "rx byte0");
		chk(rxq[1], 8'hC3, "rx byte1");
		// clocks while deselected must be ignored
		host.shift(8, 8'hFF, r0);
		host.pins(1'b1, idle_hi);
		chk(8'(rxq.size()), 8'h02, "deselected rx");
		chk({7'h0, miso_oe_n}, 8'h01, "deselected oe");
	endtask : t_four

	task automatic t_three;
		logic [7:0] r0, r1;
		host.pins(1'b1, 1'b1);
		@(posedge core_clk);
		three_wire <= 1'b1;
		tx_restart <= 1'b1;
		@(posedge core_clk);
		tx_restart <= 1'b0;
		host.pins(1'b0, 1'b1);
		rxq.delete();
		// partial byte, then clock parked high past the timeout
		host.shift(3, 8'hE0, r0);
		repeat (420) @(posedge core_clk);
		host.shift(8, 8'h96, r1);
		repeat (420) @(posedge core_clk);
		chk(r1, 8'h3C, "3w miso");
		chk(8'(rxq.size()), 8'h01, "3w count");
		chk(rxq[0], 8'h96, "3w rx");
		host.pins(1'b1, 1'b1);
		@(posedge core_clk);
		three_wire <= 1'b0;
	endtask : t_three

	task automatic t_svc;
		@(posedge core_clk);
		svc_req <= 1'b1;
		repeat (2) @(posedge core_clk);
		#1 chk({7'h0, irq_n}, 8'h00, "irq on");
		@(posedge core_clk);
		svc_req <= 1'b0;
		repeat (2) @(posedge core_clk);
		#1 chk({7'h0, irq_n}, 8'h01, "irq off");
	endtask : t_svc

	// mid-run reset with a foreign strap pattern, then back to spi
	task automatic t_strap;
		@(posedge core_clk);
		strap <= 3'h2;
		rst <= 1'b1;
		repeat (4) @(posedge core_clk);
		rst <= 1'b0;
		repeat (2) @(posedge core_clk);
		chk({7'h0, miso_oe_n}, 8'h01, "oe after reset");
		chk({7'h0, tx_taken}, 8'h00, "stray start");
		repeat (8) @(posedge core_clk);
		chk({7'h0, spi_mode_sel}, 8'h00, "foreign strap");
		@(posedge core_clk);
		strap <= 3'h1;
		rst <= 1'b1;
		repeat (4) @(posedge core_clk);
		rst <= 1'b0;
		repeat (10) @(posedge core_clk);
		t_reset;
	endtask : t_strap

	initial begin
		repeat (20000) @(posedge core_clk);
		errors++;
		$display("BAD %0t timeout", $time);
		stop_test;
	end

	initial begin
		rst = 1'b1;
		three_wire = 1'b0;
		svc_req = 1'b0;
		errors = 0;
		samples_checked = 0;
		repeat (4) @(posedge core_clk);
		rst <= 1'b0;
		repeat (10) @(posedge core_clk);
		t_reset;
		t_four(1'b0);
		t_four(1'b1);
		t_three;
		t_svc;
		t_strap;
		stop_test;
	end
endmodule : testbench

/* verilog/shp_pkg.sv */
package shp_pkg;

	// core clock
	localparam int CLK_PERIOD_NS = 25;

	// longest sclk-high time inside a three-wire transfer, rounded down to cycles
	localparam int SCLK_HIGH_MAX_US = 5;
	localparam int HIGH_CYC_INT     = (SCLK_HIGH_MAX_US * 1000) / CLK_PERIOD_NS;
	localparam int IDLE_W           = 8;
	localparam logic [IDLE_W-1:0] HIGH_MAX_CYC = IDLE_W'(HIGH_CYC_INT);

	// mode straps [bit2, bit1, bit0] selecting the spi operating mode
	localparam logic [2:0] STRAP_SPI  = 3'h1;
	// cycles after reset release before the straps are latched
	localparam logic [1:0] STRAP_WAIT = 2'h3;

	// last bit index of a byte
	localparam logic [2:0] BIT_LAST = 3'h7;

	// pins entering the core clock domain
	typedef struct packed {
		logic       sclk;
		logic       ss_n;
		logic       mosi;
		logic [2:0] strap;
	} shp_pins_t;

	localparam int PINS_W = $bits(shp_pins_t);

	typedef struct packed {
		logic              sclk_d;
		logic              ss_n_d;
		logic              active;
		logic              need_load;
		logic [2:0]        bit_cnt;
		logic [7:0]        rx_sh;
		logic [7:0]        tx_sh;
		logic [IDLE_W-1:0] idle_cnt;
		logic [7:0]        rx_data;
		logic              rx_valid;
		logic              tx_taken;
		logic              miso;
		logic              miso_oe_n;
		logic              irq_n;
		logic [1:0]        strap_cnt;
		logic              strap_done;
		logic              spi_mode_sel;
	} shp_state_t;

	localparam shp_state_t ST_RST = '{
		sclk_d:       1'b1,
		ss_n_d:       1'b1,
		active:       1'b0,
		need_load:    1'b0,
		bit_cnt:      3'h0,
		rx_sh:        8'h00,
		tx_sh:        8'h00,
		idle_cnt:     8'h00,
		rx_data:      8'h00,
		rx_valid:     1'b0,
		tx_taken:     1'b0,
		miso:         1'b0,
		miso_oe_n:    1'b1,
		irq_n:        1'b1,
		strap_cnt:    2'h0,
		strap_done:   1'b0,
		spi_mode_sel: 1'b0
	};

endpackage : shp_pkg

/* verilog/shp_port.sv */
`timescale 1ns/10ps
// Functional notes
// - four-wire: select falling starts a transfer, select rising ends it.
// - four-wire: works with serial clock idling high or idling low.
// - four-wire: data-out floats whenever select is high.
// - three-wire: transfer start and stop found from clock activity only.
// - data-in bit captured on serial clock rising edge.
// - data-out changes only after a serial clock falling edge or, in four-wire, a select falling edge.
// - every byte shifted most significant bit first, both directions.
// - multi-byte values travel least significant byte first.
// - service-request output tells host when to start transfers.
// - service-request output is active low; host pulls it up.
module shp_port (
	// clock and reset
	input  wire logic       core_clk,
	input  wire logic       rst,
	// spi pins
	input  wire logic       sclk,
	input  wire logic       ss_n,
	input  wire logic       mosi,
	output logic            miso_o,
	output logic            miso_oe_n,
	// mode straps and framing mode
	input  wire logic       mode_strap_bit0,
	input  wire logic       mode_strap_bit1,
	input  wire logic       mode_strap_bit2,
	input  wire logic       three_wire,
	output logic            spi_mode_sel,
	// user byte stream
	input  wire logic [7:0] tx_data,
	output logic            tx_taken,
	output logic [7:0]      rx_data,
	output logic            rx_valid,
	// service request
	input  wire logic       svc_req,
	output logic            irq_n
);

	shp_pkg::shp_pins_t  pins_raw;
	shp_pkg::shp_pins_t  pins_s;
	shp_pkg::shp_state_t st_r;
	shp_pkg::shp_state_t st_nxt;
	logic                rise;
	logic                fall;
	logic                ss_fall;
	logic                frame_on;
	logic                start;

	assign pins_raw = '{sclk: sclk, ss_n: ss_n, mosi: mosi,
		strap: {mode_strap_bit2, mode_strap_bit1, mode_strap_bit0}};

	shp_sync #(.W(shp_pkg::PINS_W)) u_sync (
		.core_clk (core_clk),
		.rst      (rst),
		.d        (pins_raw),
		.q        (pins_s)
	);

	// edges seen only on synced levels
	// no edges until the synchronisers hold real pin levels; their reset zeros look like edges
	assign rise     = st_r.strap_done & ~st_r.sclk_d & pins_s.sclk;
	assign fall     = st_r.strap_done & st_r.sclk_d & ~pins_s.sclk;
	assign ss_fall  = st_r.strap_done & st_r.ss_n_d & ~pins_s.ss_n;
	// select ignored in three-wire mode
	assign frame_on = three_wire ? st_r.active : ~pins_s.ss_n;
	// three-wire idles high, so the first falling edge opens the transfer
	assign start    = three_wire ? (~st_r.active & fall) : ss_fall;

	always_comb begin
		st_nxt          = st_r;
		st_nxt.rx_valid = 1'b0;
		st_nxt.tx_taken = 1'b0;
		st_nxt.sclk_d   = pins_s.sclk;
		st_nxt.ss_n_d   = pins_s.ss_n;
		st_nxt.irq_n    = ~svc_req;
		// single slave in three-wire, so drive always there
		// kept floating while the synced select still shows its reset zero
		st_nxt.miso_oe_n = ~st_r.strap_done | (three_wire ? 1'b0 : pins_s.ss_n);

		// straps caught a few cycles after release, once the synchroniser has settled
		if (!st_r.strap_done) begin
			st_nxt.strap_cnt = st_r.strap_cnt + 2'h1;
			if (st_r.strap_cnt == shp_pkg::STRAP_WAIT) begin
				st_nxt.strap_done   = 1'b1;
				st_nxt.spi_mode_sel = (pins_s.strap == shp_pkg::STRAP_SPI);
			end
		end

		// long high clock ends a three-wire transfer
		if (three_wire && pins_s.sclk) begin
			if (st_r.idle_cnt != shp_pkg::HIGH_MAX_CYC) begin
				st_nxt.idle_cnt = st_r.idle_cnt + 8'h01;
			end
		end else begin
			st_nxt.idle_cnt = '0;
		end
		if (three_wire && st_r.active && pins_s.sclk &&
			st_r.idle_cnt == shp_pkg::HIGH_MAX_CYC - 8'h01) begin
			st_nxt.active    = 1'b0;
			st_nxt.bit_cnt   = '0;
			st_nxt.need_load = 1'b0;
		end
		if (!three_wire && pins_s.ss_n) begin
			st_nxt.active    = 1'b0;
			st_nxt.bit_cnt   = '0;
			st_nxt.need_load = 1'b0;
		end

		if (start) begin
			// first byte out straight away; idle level of clock does not matter
			st_nxt.active    = 1'b1;
			st_nxt.bit_cnt   = '0;
			st_nxt.need_load = 1'b0;
			st_nxt.tx_sh     = tx_data;
			st_nxt.miso      = tx_data[7];
			st_nxt.tx_taken  = 1'b1;
		end else if (frame_on && rise) begin
			st_nxt.rx_sh   = {st_r.rx_sh[6:0], pins_s.mosi};
			st_nxt.bit_cnt = st_r.bit_cnt + 3'h1;
			if (st_r.bit_cnt == shp_pkg::BIT_LAST) begin
				st_nxt.rx_data   = {st_r.rx_sh[6:0], pins_s.mosi};
				st_nxt.rx_valid  = 1'b1;
				st_nxt.need_load = 1'b1;
			end
		end else if (frame_on && fall) begin
			if (st_r.need_load) begin
				// bytes go out in the order the user hands them over
				st_nxt.tx_sh     = tx_data;
				st_nxt.miso      = tx_data[7];
				st_nxt.need_load = 1'b0;
				st_nxt.tx_taken  = 1'b1;
			end else if (st_r.bit_cnt != 3'h0) begin
				st_nxt.tx_sh = {st_r.tx_sh[6:0], 1'b0};
				st_nxt.miso  = st_r.tx_sh[6];
			end
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			st_r <= shp_pkg::ST_RST;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign miso_o       = st_r.miso;
	assign miso_oe_n    = st_r.miso_oe_n;
	assign spi_mode_sel = st_r.spi_mode_sel;
	assign tx_taken     = st_r.tx_taken;
	assign rx_data      = st_r.rx_data;
	assign rx_valid     = st_r.rx_valid;
	assign irq_n        = st_r.irq_n;

	property p_ss_start;
		@(posedge core_clk) disable iff (rst)
		(!three_wire && ss_fall) |=> (st_r.active && st_r.bit_cnt == 3'h0 && tx_taken);
	endproperty
	a_ss_start: assert property (p_ss_start) else $error("select fall did not start");

	property p_ss_end;
		@(posedge core_clk) disable iff (rst)
		(!three_wire && pins_s.ss_n) |=> ($stable(st_r.rx_sh) && st_r.bit_cnt == 3'h0);
	endproperty
	a_ss_end: assert property (p_ss_end) else $error("bits taken while deselected");

	property p_hiz;
		@(posedge core_clk) disable iff (rst)
		(!three_wire && pins_s.ss_n) ##1 !three_wire |-> miso_oe_n;
	endproperty
	a_hiz: assert property (p_hiz) else $error("data-out driven while deselected");

	property p_3w_end;
		@(posedge core_clk) disable iff (rst)
		(three_wire && st_r.active && pins_s.sclk &&
			st_r.idle_cnt == shp_pkg::HIGH_MAX_CYC - 8'h01) |=> !st_r.active;
	endproperty
	a_3w_end: assert property (p_3w_end) else $error("three-wire end missed");

	property p_capture;
		@(posedge core_clk) disable iff (rst)
		(frame_on && rise && !start) |=>
			st_r.rx_sh == {$past(st_r.rx_sh[6:0]), $past(pins_s.mosi)};
	endproperty
	a_capture: assert property (p_capture) else $error("rising edge capture wrong");

	property p_miso_hold;
		@(posedge core_clk) disable iff (rst)
		(!fall && !ss_fall) |=> $stable(miso_o);
	endproperty
	a_miso_hold: assert property (p_miso_hold) else $error("data-out moved off a fall");

	property p_byte;
		@(posedge core_clk) disable iff (rst)
		(frame_on && rise && !start && st_r.bit_cnt == shp_pkg::BIT_LAST) |=>
			(rx_valid && rx_data == {$past(st_r.rx_sh[6:0]), $past(pins_s.mosi)});
	endproperty
	a_byte: assert property (p_byte) else $error("received byte wrong");

	property p_irq;
		@(posedge core_clk) disable iff (rst)
		svc_req ##1 svc_req |-> !irq_n;
	endproperty
	a_irq: assert property (p_irq) else $error("service request not low");

	property p_valid_src;
		@(posedge core_clk) disable iff (rst)
		rx_valid |-> ($past(rise) && !$past(rx_valid));
	endproperty
	a_valid_src: assert property (p_valid_src) else $error("byte without rising edge");

	property p_cov_byte;
		@(posedge core_clk) disable iff (rst)
		rx_valid;
	endproperty
	c_cov_byte: cover property (p_cov_byte);

	property p_cov_3w;
		@(posedge core_clk) disable iff (rst)
		three_wire && st_r.active ##1 !st_r.active;
	endproperty
	c_cov_3w: cover property (p_cov_3w);

	property p_cov_reload;
		@(posedge core_clk) disable iff (rst)
		st_r.need_load ##1 tx_taken;
	endproperty
	c_cov_reload: cover property (p_cov_reload);

endmodule : shp_port

/* verilog/shp_sync.sv */
`timescale 1ns/10ps
module shp_sync #(
	parameter int W = 1
) (
	// clock and reset
	input  wire logic         core_clk,
	input  wire logic         rst,
	// async in, synced out
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);

	logic [W-1:0] meta_r;

	// one two-stage chain per bit; the first stage feeds only the second
	for (genvar i = 0; i < W; i++) begin : g_bit
		always_ff @(posedge core_clk or posedge rst) begin
			if (rst) begin
				meta_r[i] <= 1'b0;
				q[i]      <= 1'b0;
			end else begin
				meta_r[i] <= d[i];
				q[i]      <= meta_r[i];
			end
		end
	end

endmodule : shp_sync
